// ---- design/csi_top.sv ----
// csi_top: codec serial interface with APB registers, four-word tx/rx buffers and pin control
// assumes APB master on clk; codec pins asynchronous and synchronised here
`default_nettype none
// Operation
// [RL1] bit clock output mode: device generates bit clock and drives the pin
// [RL2] bit clock input mode: codec supplies bit clock, device uses it
// [RL3] while enabled, interface owns direction of all four pins
// [RL4] data out pin is output only and driven during transmitted words
// [RL5] idle data out slots are high-impedance or low per idle mode bit
// [RL6] data in pin is input only, sampled for received bits
// [RL7] frame sync pin direction follows frame sync direction bit
// [RL8] data transfers are aligned to frame sync, whoever drives it
// [RL9] buffer words are left justified, msb at bit 15
// [RL10] short words: unused low receive bits written as zero
// [RL11] short words: unused low transmit bits ignored, not sent
// [RL12] word length programmable up to 16 bits
// [RL13] up to 16 slots per frame, at most 256 bit clocks
// [RL14] four samples buffered each direction without processor help
// [RL15] engine uses shadow buffers so processor access never conflicts
// [RL16] supports multi-channel framed, I2S and AC-Link framing
// [RL17] 16-bit shift register, shifted msb first
// [RL18] frame sync master when direction bit clear, slave when set
// [RL19] disable resets bit clock, frame and buffer counters, stops clocks
// [RL20] word length field holds length minus one
// [RL21] when disabled, data out and frame sync are not driven
module csi_top
  import csi_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [csi_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   sck_i,
  output logic                        sck_o,
  output logic                        sck_oe,
  output logic                        sdo_o,
  output logic                        sdo_oe,
  input  wire logic                   sdi_i,
  input  wire logic                   fs_i,
  output logic                        fs_o,
  output logic                        fs_oe
);
  import csi_pkg::*;

  // configuration registers
  logic [31:0] ctrl1_r, ctrl1_nxt;
  logic [31:0] ctrl2_r, ctrl2_nxt;
  logic [11:0] div_r, div_nxt;
  csi_cfg_t    cfg;

  // processor-side buffers and engine shadows
  logic [DATA_W-1:0] txbuf_r [NBUF];
  logic [DATA_W-1:0] rxbuf_r [NBUF];
  logic [DATA_W-1:0] txsh_r  [NBUF];
  logic [DATA_W-1:0] rxsh_r  [NBUF];
  logic              frame_done_r, frame_done_nxt;
  logic              rx_ready_r, rx_ready_nxt;

  // serial engine state
  logic [DATA_W-1:0] shift_r, shift_nxt;
  logic [3:0]        bit_r, bit_nxt;
  logic [3:0]        slot_r, slot_nxt;
  logic [FRM_W-1:0]  fcnt_r, fcnt_nxt;
  logic [BUF_AW-1:0] addr_r, addr_nxt;
  logic              active_r, active_nxt;
  logic              sending_r, sending_nxt;
  logic              fs_gen_r, fs_gen_nxt;
  logic              i2s_ph_r, i2s_ph_nxt;
  logic              sdo_r, sdo_nxt;
  csi_pins_t         pins_r, pins_nxt;
  logic [31:0]       prdata_r, prdata_nxt;
  logic              pslverr_r, pslverr_nxt;

  logic sck_s, sck_rise_s, sck_fall_s;
  logic fs_s, fs_rise_s, fs_fall_s;
  logic sdi_s;
  logic gen_sck, gen_rise, gen_fall;
  logic brise, bfall;
  logic [3:0] wl_m1, fw_m1;
  logic       start, last_bit, last_slot;
  logic       wr_en, rd_en, hit;
  logic [1:0] widx;

  assign cfg.enable         = ctrl1_r[C1_EN];
  assign cfg.fs_dir_in      = ctrl1_r[C1_FSDIR];
  assign cfg.idle_low       = ctrl1_r[C1_IDLE];
  assign cfg.mode           = csi_mode_t'(ctrl1_r[C1_MODE_LO +: 2]);
  assign cfg.word_len_m1    = ctrl2_r[C2_WS_LO +: WS_W];
  assign cfg.frame_words_m1 = ctrl2_r[C2_FSG_LO +: 4];
  assign cfg.ck_dir_in      = ctrl2_r[C2_CKDIR];
  assign cfg.clk_div        = div_r;

  csi_sync u_sck (.clk(clk), .rst(rst), .d(sck_i), .q(sck_s), .rise(sck_rise_s),
                  .fall(sck_fall_s));
  csi_sync u_fs  (.clk(clk), .rst(rst), .d(fs_i), .q(fs_s), .rise(fs_rise_s),
                  .fall(fs_fall_s));
  csi_sync u_sdi (.clk(clk), .rst(rst), .d(sdi_i), .q(sdi_s), .rise(), .fall());

  csi_bitclk u_bck (
    .clk   (clk),
    .rst   (rst),
    .clear (!cfg.enable || cfg.ck_dir_in), // RL19
    .div   (cfg.clk_div),
    .sck   (gen_sck),
    .rise  (gen_rise),
    .fall  (gen_fall)
  );

  // bit clock source select
  assign brise = cfg.enable && (cfg.ck_dir_in ? sck_rise_s : gen_rise); // RL2
  assign bfall = cfg.enable && (cfg.ck_dir_in ? sck_fall_s : gen_fall);

  // ac-link fixes 16-bit slots and 16-slot frame
  assign wl_m1 = cfg.mode[1] ? AC_WS : cfg.word_len_m1; // RL20 RL12
  assign fw_m1 = cfg.mode[1] ? AC_FSG : cfg.frame_words_m1; // RL13
  assign last_bit  = (bit_r == wl_m1);
  assign last_slot = (slot_r == fw_m1);

  // frame start, sampled on bit clock rise, data begins next period
  always_comb begin
    start = 1'b0;
    if (cfg.fs_dir_in) begin // RL18
      if (!active_r || (last_bit && last_slot)) begin
        unique case (cfg.mode) // RL16
          CSI_I2S:  start = fs_s != i2s_ph_r;
          default:  start = fs_s;
        endcase
      end
    end else begin
      start = !active_r || (last_bit && last_slot);
    end
  end

  always_comb begin
    shift_nxt      = shift_r;
    bit_nxt        = bit_r;
    slot_nxt       = slot_r;
    fcnt_nxt       = fcnt_r;
    addr_nxt       = addr_r;
    active_nxt     = active_r;
    sending_nxt    = sending_r;
    fs_gen_nxt     = fs_gen_r;
    i2s_ph_nxt     = i2s_ph_r;
    sdo_nxt        = sdo_r;
    frame_done_nxt = 1'b0;
    if (!cfg.enable) begin // RL19
      bit_nxt     = 4'h0;
      slot_nxt    = 4'h0;
      fcnt_nxt    = '0;
      addr_nxt    = '0;
      active_nxt  = 1'b0;
      sending_nxt = 1'b0;
      fs_gen_nxt  = 1'b0;
      i2s_ph_nxt  = 1'b0;
    end else if (bfall) begin
      // drive next bit out on falling edge, msb first
      if (active_r) begin
        sdo_nxt     = shift_r[DATA_W-1]; // RL17 RL4
        sending_nxt = 1'b1;
      end else begin
        sending_nxt = 1'b0;
      end
      // master frame sync waveform
      unique case (cfg.mode)
        CSI_MULTI: fs_gen_nxt = start && !cfg.fs_dir_in && (!active_r || last_bit);
        CSI_I2S:   fs_gen_nxt = (last_bit && last_slot) ? ~fs_gen_r : fs_gen_r;
        default:   fs_gen_nxt = (fcnt_r == 8'hFF) || (fcnt_r < AC_FS_HIGH);
      endcase
    end else if (brise) begin
      fcnt_nxt = fcnt_r + 8'h01;
      if (active_r) begin
        // msb-first capture, low bits zero for short words
        shift_nxt = {shift_r[DATA_W-2:0], sdi_s}; // RL17
        bit_nxt   = bit_r + 4'h1;
        if (last_bit) begin
          bit_nxt  = 4'h0;
          slot_nxt = slot_r + 4'h1;
          addr_nxt = addr_r + 2'h1; // RL14
          if (last_slot) begin
            slot_nxt       = 4'h0;
            addr_nxt       = '0;
            active_nxt     = 1'b0;
            frame_done_nxt = 1'b1;
          end
        end
      end
      if (start) begin // RL8
        active_nxt = 1'b1;
        bit_nxt    = 4'h0;
        slot_nxt   = 4'h0;
        addr_nxt   = '0;
        fcnt_nxt   = '0;
        i2s_ph_nxt = fs_s;
      end
    end
  end

  // sequential engine plus shadow load/capture
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_r      <= '0;
      bit_r        <= 4'h0;
      slot_r       <= 4'h0;
      fcnt_r       <= '0;
      addr_r       <= '0;
      active_r     <= 1'b0;
      sending_r    <= 1'b0;
      fs_gen_r     <= 1'b0;
      i2s_ph_r     <= 1'b0;
      sdo_r        <= 1'b0;
      frame_done_r <= 1'b0;
    end else begin
      bit_r        <= bit_nxt;
      slot_r       <= slot_nxt;
      fcnt_r       <= fcnt_nxt;
      addr_r       <= addr_nxt;
      active_r     <= active_nxt;
      sending_r    <= sending_nxt;
      fs_gen_r     <= fs_gen_nxt;
      i2s_ph_r     <= i2s_ph_nxt;
      sdo_r        <= sdo_nxt;
      frame_done_r <= frame_done_nxt;
      shift_r      <= shift_nxt;
      if (brise && active_r && last_bit) begin
        // store received word left justified, zero tail
        rxsh_r[addr_r] <= {shift_r[DATA_W-2:0], sdi_s} << (4'hF - wl_m1); // RL9 RL10
        shift_r <= (last_slot && !start) ? shift_nxt : txsh_r[addr_nxt]; // RL11
      end
      if (brise && start) begin
        shift_r <= txsh_r[2'h0];
      end
    end
  end

  // shadow exchange at frame end; processor only touches the front buffers
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NBUF; i++) begin
        txsh_r[i] <= '0;
        rxbuf_r[i] <= '0;
      end
    end else if (frame_done_r || (cfg.enable && !active_r && !brise)) begin
      for (int i = 0; i < NBUF; i++) begin
        txsh_r[i] <= txbuf_r[i]; // RL15
        if (frame_done_r) begin
          rxbuf_r[i] <= rxsh_r[i]; // RL15
        end
      end
    end
  end

  // apb slave, zero wait state
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign widx  = paddr[3:2];
  assign hit   = (paddr[7:4] == 4'h0) || (paddr[7:4] == 4'h1) || (paddr[7:4] == 4'h2);

  always_comb begin
    ctrl1_nxt    = ctrl1_r;
    ctrl2_nxt    = ctrl2_r;
    div_nxt      = div_r;
    rx_ready_nxt = rx_ready_r | frame_done_r;
    prdata_nxt   = prdata_r;
    pslverr_nxt  = psel && !penable && !hit;
    if (wr_en) begin
      unique case (paddr)
        OFS_CTRL1:  ctrl1_nxt = {27'h0, pwdata[4:0]};
        OFS_CTRL2:  ctrl2_nxt = {23'h0, pwdata[8:0]};
        OFS_CLKDIV: div_nxt   = pwdata[11:0];
        default:    ;
      endcase
    end
    if (rd_en) begin
      prdata_nxt = 32'h0000_0000;
      if (paddr == OFS_CTRL1) prdata_nxt = ctrl1_r;
      if (paddr == OFS_CTRL2) prdata_nxt = ctrl2_r;
      if (paddr == OFS_CLKDIV) prdata_nxt = {20'h0, div_r};
      if (paddr == OFS_STAT) begin
        prdata_nxt = {16'h0, 2'h0, addr_r, slot_r, 6'h0, rx_ready_r, active_r};
        rx_ready_nxt = frame_done_r;
      end
      if (paddr[7:4] == 4'h1) prdata_nxt = {16'h0, txbuf_r[widx]};
      if (paddr[7:4] == 4'h2) prdata_nxt = {16'h0, rxbuf_r[widx]};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl1_r    <= CTRL1_RST;
      ctrl2_r    <= CTRL2_RST;
      div_r      <= CLKDIV_RST;
      rx_ready_r <= 1'b0;
      prdata_r   <= 32'h0000_0000;
      pslverr_r  <= 1'b0;
      for (int i = 0; i < NBUF; i++) begin
        txbuf_r[i] <= '0;
      end
    end else begin
      ctrl1_r    <= ctrl1_nxt;
      ctrl2_r    <= ctrl2_nxt;
      div_r      <= div_nxt;
      rx_ready_r <= rx_ready_nxt;
      prdata_r   <= prdata_nxt;
      pslverr_r  <= pslverr_nxt;
      if (wr_en && paddr[7:4] == 4'h1) begin
        txbuf_r[widx] <= pwdata[15:0]; // RL9
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = pslverr_r;

  // pin drivers
  always_comb begin
    pins_nxt.sck_o  = gen_sck;
    pins_nxt.sck_oe = cfg.enable && !cfg.ck_dir_in; // RL1 RL3
    pins_nxt.sdo_o  = sending_nxt ? sdo_nxt : 1'b0;
    pins_nxt.sdo_oe = cfg.enable && (sending_nxt || cfg.idle_low); // RL4 RL5 RL21
    pins_nxt.fs_o   = fs_gen_nxt;
    pins_nxt.fs_oe  = cfg.enable && !cfg.fs_dir_in; // RL7 RL21
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pins_r <= '0;
    end else begin
      pins_r <= pins_nxt;
    end
  end

  assign sck_o  = pins_r.sck_o;
  assign sck_oe = pins_r.sck_oe;
  assign sdo_o  = pins_r.sdo_o;
  assign sdo_oe = pins_r.sdo_oe; // RL6: no output enable for data in
  assign fs_o   = pins_r.fs_o;
  assign fs_oe  = pins_r.fs_oe;
endmodule
`default_nettype wire

// ---- design/csi_pkg.sv ----
// csi_pkg: register map, field layout, reset values and carrier types for the codec serial interface
// assumes a 32-bit APB slave, word-aligned registers
`default_nettype none
package csi_pkg;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned WS_W        = 4;
  localparam int unsigned NBUF        = 4;
  localparam int unsigned BUF_AW      = 2;
  localparam int unsigned FRM_W       = 8;
  localparam int unsigned APB_AW      = 8;
  // byte offsets
  localparam logic [7:0] OFS_CTRL1    = 8'h00;
  localparam logic [7:0] OFS_CTRL2    = 8'h04;
  localparam logic [7:0] OFS_CLKDIV   = 8'h08;
  localparam logic [7:0] OFS_STAT     = 8'h0C;
  localparam logic [7:0] OFS_TXBUF0   = 8'h10;
  localparam logic [7:0] OFS_RXBUF0   = 8'h20;
  // control one fields
  localparam int unsigned C1_EN       = 0;
  localparam int unsigned C1_FSDIR    = 1;
  localparam int unsigned C1_IDLE     = 2;
  localparam int unsigned C1_MODE_LO  = 3;
  // control two fields
  localparam int unsigned C2_WS_LO    = 0;
  localparam int unsigned C2_FSG_LO   = 4;
  localparam int unsigned C2_CKDIR    = 8;
  localparam logic [31:0] CTRL1_RST   = 32'h0000_0000;
  localparam logic [31:0] CTRL2_RST   = 32'h0000_000F;
  localparam logic [11:0] CLKDIV_RST  = 12'h001;
  // ac-link framing
  localparam logic [7:0] AC_FS_HIGH   = 8'h0F;
  localparam logic [3:0] AC_WS        = 4'hF;
  localparam logic [3:0] AC_FSG       = 4'hF;

  typedef enum logic [1:0] {
    CSI_MULTI = 2'b00,
    CSI_I2S   = 2'b01,
    CSI_AC16  = 2'b10,
    CSI_AC20  = 2'b11
  } csi_mode_t;

  typedef struct packed {
    logic        enable;
    logic        fs_dir_in;
    logic        ck_dir_in;
    logic        idle_low;
    csi_mode_t   mode;
    logic [3:0]  word_len_m1;
    logic [3:0]  frame_words_m1;
    logic [11:0] clk_div;
  } csi_cfg_t;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic sdo_o;
    logic sdo_oe;
    logic fs_o;
    logic fs_oe;
  } csi_pins_t;
endpackage
`default_nettype wire

// ---- design/csi_sync.sv ----
// csi_sync: two-flop synchroniser with edge detection on the synchronised output
// assumes async input, single clk domain
`default_nettype none
module csi_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q,
  output logic      rise,
  output logic      fall
);
  logic meta_r;
  logic q_r;
  logic q_d_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= 1'b0;
      q_r    <= 1'b0;
      q_d_r  <= 1'b0;
    end else begin
      meta_r <= d;
      q_r    <= meta_r;
      q_d_r  <= q_r;
    end
  end

  assign q    = q_r;
  assign rise = q_r & ~q_d_r;
  assign fall = ~q_r & q_d_r;
endmodule
`default_nettype wire

// ---- design/csi_bitclk.sv ----
// csi_bitclk: internal bit clock divider, toggles at clk/(2*(div+1)), held low when div is 0
// assumes div is stable while running; clear holds it reset
`default_nettype none
module csi_bitclk (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clear,
  input  wire logic [11:0] div,
  output logic             sck,
  output logic             rise,
  output logic             fall
);
  logic [11:0] cnt_r;
  logic [11:0] cnt_nxt;
  logic        sck_r;
  logic        sck_nxt;
  logic        tick;

  always_comb begin
    tick    = (cnt_r == div) && (div != 12'h000);
    cnt_nxt = tick ? 12'h000 : cnt_r + 12'h001;
    sck_nxt = tick ? ~sck_r : sck_r;
    if (clear || (div == 12'h000)) begin
      cnt_nxt = 12'h000;
      sck_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 12'h000;
      sck_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      sck_r <= sck_nxt;
    end
  end

  assign sck  = sck_r;
  assign rise = tick && !sck_r && !clear;
  assign fall = tick && sck_r && !clear;
endmodule
`default_nettype wire

// ---- tb/csi_checker_assertions.sv ----
// csi_checker: pin ownership and bit clock rate seen from the top ports
// assumes bound into csi_top; config is tracked from completed apb writes
`default_nettype none
module csi_checker (
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic                       pready,
  input wire logic [csi_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0]                pwdata,
  input wire logic                       sck_o,
  input wire logic                       sck_oe,
  input wire logic                       sdo_oe,
  input wire logic                       fs_oe
);
  import csi_pkg::*;
  logic [2:0]  c1_r, c1_nxt;
  logic        ck_r, ck_nxt, sk_r, sk_nxt, hv_r, hv_nxt, wr, tog;
  logic [11:0] dv_r, dv_nxt;
  logic [12:0] hc_r, hc_nxt;
  assign wr  = psel & penable & pwrite & pready;
  assign tog = sck_o != sk_r;
  always_comb begin
    c1_nxt = wr && paddr == OFS_CTRL1 ? pwdata[2:0] : c1_r;
    ck_nxt = wr && paddr == OFS_CTRL2 ? pwdata[C2_CKDIR] : ck_r;
    dv_nxt = wr && paddr == OFS_CLKDIV ? pwdata[11:0] : dv_r;
    sk_nxt = sck_o;
    // half period counter, trusted after one toggle
    hc_nxt = tog ? 13'h0000 : hc_r + 13'h0001;
    hv_nxt = c1_r[C1_EN] & sck_oe & ~wr & (hv_r | tog);
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      c1_r <= 3'h0;
      ck_r <= 1'h0;
      dv_r <= CLKDIV_RST;
      sk_r <= 1'h0;
      hc_r <= 13'h0000;
      hv_r <= 1'h0;
    end else begin
      c1_r <= c1_nxt;
      ck_r <= ck_nxt;
      dv_r <= dv_nxt;
      sk_r <= sk_nxt;
      hc_r <= hc_nxt;
      hv_r <= hv_nxt;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_sck_drive: assert property ((c1_r[0] && !ck_r) [*3] |-> sck_oe)
    else $error("bit clock not driven");
  a_sck_input: assert property ((c1_r[0] && ck_r) [*3] |-> !sck_oe)
    else $error("bit clock driven in input mode");
  a_fs_master: assert property ((c1_r[0] && !c1_r[1]) [*3] |-> fs_oe)
    else $error("frame sync not driven as master");
  a_fs_slave: assert property ((c1_r[0] && c1_r[1]) [*3] |-> !fs_oe)
    else $error("frame sync driven as slave");
  a_idle_low: assert property ((c1_r[0] && c1_r[2]) [*3] |-> sdo_oe)
    else $error("data out released in idle low mode");
  a_off_quiet: assert property ((!c1_r[0]) [*3] |-> !(sdo_oe || fs_oe || sck_oe))
    else $error("pin driven while disabled");
  a_clk_stop: assert property ((!c1_r[0]) [*4] |-> $stable(sck_o))
    else $error("bit clock runs while disabled");
  a_sck_rate: assert property (hv_r && tog |-> hc_r == {1'h0, dv_r})
    else $error("bit clock half period wrong");
  c_master: cover property (c1_r[0] && sck_oe && fs_oe);
  c_slave: cover property (c1_r[0] && c1_r[1] && ck_r);
  c_idle: cover property (c1_r[0] && c1_r[2] && sdo_oe);
endmodule

bind csi_top csi_checker u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata), .sck_o(sck_o),
  .sck_oe(sck_oe), .sdo_oe(sdo_oe), .fs_oe(fs_oe));
`default_nettype wire

// ---- tb/csi_codec_model.sv ----
// csi_codec_model: external codec, makes bit clock and frame sync when gen is high
// assumes the bench resolves the shared lines; msb first, change on fall
`default_nettype none
module csi_codec_model (
  input  wire logic        gen,
  input  wire logic [4:0]  nbits,
  input  wire logic [15:0] tx,
  input  wire logic        sck,
  input  wire logic        fs,
  input  wire logic        sdo,
  output logic             sck_gen,
  output logic             fs_gen,
  output logic             sdi,
  output logic [15:0]      got,
  output int               words
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] sh;
  logic [4:0]  idx, fc;
  initial begin
    sck_gen = 1'h0;
    fs_gen = 1'h0;
    sdi = 1'h0;
    got = 16'h0000;
    words = 0;
    sh = 16'h0000;
    idx = 5'h10;
    fc = 5'h00;
  end
  always #62.5 if (gen) sck_gen = ~sck_gen;
  always @(posedge sck) begin
    sh = {sh[14:0], sdo};
    if (fs) begin
      got = sh;
      words = words + 1;
      idx = 5'h00;
    end
  end
  always @(negedge sck) begin
    if (idx < nbits) begin
      sdi = tx[4'hF - idx[3:0]];
      idx = idx + 5'h01;
    end else begin
      // released line: no stale value
      sdi = ~sdi;
    end
    if (gen) begin
      fc = fc >= nbits - 5'h01 ? 5'h00 : fc + 5'h01;
      fs_gen = fc == nbits - 5'h01;
    end
  end
endmodule
`default_nettype wire

// ---- tb/test_codec_serial_interface_pins.sv ----
// test_codec_serial_interface_pins: registers, pin ownership, serial data both ways
// assumes csi_codec_model at the pins and the bound checker
`default_nettype none
module test_codec_serial_interface_pins;
  timeunit 1ns;
  timeprecision 100ps;
  import csi_pkg::*;
  logic              clk, rst, psel, penable, pwrite, pready, pslverr, err, sdi;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              sck_o, sck_oe, sdo_o, sdo_oe, fs_o, fs_oe;
  logic              gen, sck_gen, fs_gen, sck_w, fs_w, sdo_w;
  logic [4:0]        nbits;
  logic [15:0]       ctx, got;
  int                words, fs_rises;
  int                err_count = 0;
  int                n_compared = 0;
  assign sck_w = sck_oe ? sck_o : gen & sck_gen;
  assign fs_w = fs_oe ? fs_o : gen & fs_gen;
  assign sdo_w = sdo_oe & sdo_o;
  csi_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .sdi_i(sdi), .fs_i(fs_w), .fs_o(fs_o), .fs_oe(fs_oe));
  csi_codec_model u_cdc (.gen(gen), .nbits(nbits), .tx(ctx), .sck(sck_w), .fs(fs_w),
    .sdo(sdo_w), .sck_gen(sck_gen), .fs_gen(fs_gen), .sdi(sdi), .got(got), .words(words));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge fs_o) fs_rises++;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic final_report;
    $display("compared=%0d mismatches=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic t_reset;
    bus(1'h0, OFS_CTRL1, 32'h0000_0000);
    chk(rd, CTRL1_RST);
    bus(1'h0, OFS_CTRL2, 32'h0000_0000);
    chk(rd, CTRL2_RST);
    chk({29'h0, sck_oe, sdo_oe, fs_oe}, 32'h0000_0000);
    bus(1'h0, 8'h30, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
  endtask
  // one run of traffic both ways, device master or slave
  task automatic t_link(input logic [3:0] ws, input logic slv, input logic idl);
    int w0;
    logic [15:0] m;
    m = 16'hFFFF << (15 - ws);
    nbits <= {1'h0, ws} + 5'h01;
    ctx <= 16'h96E1;
    bus(1'h1, OFS_CLKDIV, 32'h0000_0003);
    bus(1'h1, OFS_CTRL2, {23'h0, slv, 4'h0, ws});
    for (int i = 0; i < 4; i++) bus(1'h1, OFS_TXBUF0 + 8'(4 * i), 32'h0000_A5C3);
    gen <= slv;
    bus(1'h1, OFS_CTRL1, {29'h0, idl, slv, 1'h1});
    w0 = words;
    for (int i = 0; i < 20000 && words < w0 + 6; i++) @(posedge clk);
    chk({31'h0, words >= w0 + 6}, 32'h0000_0001);
    chk({30'h0, sck_oe, fs_oe}, {30'h0, ~slv, ~slv});
    if (idl) chk({31'h0, sdo_oe}, 32'h0000_0001);
    chk(got & (16'hFFFF >> (15 - ws)), 16'hA5C3 >> (15 - ws));
    bus(1'h0, OFS_RXBUF0, 32'h0000_0000);
    chk(rd, {16'h0000, 16'h96E1 & m});
    bus(1'h0, OFS_STAT, 32'h0000_0000);
    chk(rd & 32'h0000_0003, 32'h0000_0003);
    bus(1'h1, OFS_CTRL1, 32'h0000_0000);
    gen <= 1'h0;
    repeat (8) @(posedge clk);
    chk({29'h0, sck_oe, sdo_oe, fs_oe}, 32'h0000_0000);
    bus(1'h0, OFS_STAT, 32'h0000_0000);
    chk(rd & 32'h0000_0001, 32'h0000_0000);
  endtask
  task automatic t_modes;
    bus(1'h1, OFS_CTRL2, 32'h0000_000F);
    for (int md = 0; md < 4; md++) begin
      fs_rises = 0;
      bus(1'h1, OFS_CTRL1, {27'h0, 2'(md), 3'h1});
      repeat (2600) @(posedge clk);
      chk({31'h0, fs_rises > 0}, 32'h0000_0001);
      bus(1'h1, OFS_CTRL1, 32'h0000_0000);
    end
  endtask
  initial begin
    rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    gen = 1'h0;
    nbits = 5'h10;
    ctx = 16'h0000;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    t_reset;
    t_link(4'hF, 1'h0, 1'h0);
    t_link(4'h7, 1'h0, 1'h1);
    t_link(4'hF, 1'h1, 1'h0);
    t_modes;
    final_report;
  end
  // whole run is near 0.13 ms
  initial begin
    #500_000;
    err_count++;
    final_report;
  end
endmodule
`default_nettype wire
